/* bench/scg_ctl_model.sv */
// stand-in for the serial controller on the glue's byte bus
`timescale 1ns/1ns
`default_nettype none
module scg_ctl_model (
    input wire logic clk,             // card clock
    input wire logic [1:0] scc_addr,  // controller port
    input wire logic scc_wr,          // write strobe
    input wire logic scc_rd,          // read strobe
    input wire logic [7:0] scc_wdata, // write byte
    output logic [7:0] scc_rdata,     // read byte
    output logic [9:0] wr_log [0:7],  // {port,byte} per write
    output int wr_cnt                 // writes seen
);
    //=============================================================
    // bus behaviour
    logic [7:0] last_q = 8'h00;
    initial wr_cnt = 0;
    // read answers only inside the strobe cycle; otherwise the inverse of
    // the last byte, so a late sample by the glue cannot pass by chance
    assign scc_rdata = scc_rd ? 8'h50 + {6'h00, scc_addr} : ~last_q;
    // every write is logged, pointer writes included
    always @(posedge clk) begin
        if (scc_rd) begin
            last_q <= scc_rdata;
        end
        if (scc_wr) begin
            wr_log[wr_cnt[2:0]] <= {scc_addr, scc_wdata};
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* bench/serial_controller_fifo_glue_tb_top.sv */
// self-checking bench for the serial card fifo glue
`timescale 1ns/1ns
`default_nettype none
module serial_controller_fifo_glue_tb_top;
    import scg_pkg::*;
    //=============================================================
    // stimulus and observed signals
    logic clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, fifo_en = 0, rx_source_sel = 0;
    logic rx_clk_route_en = 0, tx_fifo_rst = 0, rx_fifo_rst = 0, rx_tmo_en = 0, rx_pattern_irq_en = 0;
    logic wait_req_a = 0, term_ready_req_a = 0, rx_req_b = 0, tx_clk_pin_b = 0;
    logic line_rxd = 0, line_rx_clk = 0, line_dsr = 0, io_ack, io_ready, scc_wr, scc_rd;
    logic rx_data_a, rx_data_b, rx_clk_in_a, rx_clk_in_b, carrier_in_b;
    logic clear_to_send_b_n, sync_in_b_n;
    logic [1:0] io_addr = 0, scc_addr, brg_clk, line_code_a, line_code_b;
    logic [3:0] irq_clear = 0, irq_status;
    logic [5:0] fifo_stat;
    logic [7:0] io_wdata = 0, rx_pattern_irq_val = 0, io_rdata, scc_wdata, scc_rdata;
    logic [9:0] wr_log [0:7];
    int wr_cnt, err_total = 0, check_count = 0, cyc = 0, n0;
    scg_top i_dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
        .io_ready(io_ready), .fifo_en(fifo_en), .rx_source_sel(rx_source_sel),
        .rx_clk_route_en(rx_clk_route_en), .tx_fifo_rst(tx_fifo_rst),
        .rx_fifo_rst(rx_fifo_rst), .rx_tmo_en(rx_tmo_en), .rx_pattern_irq_en(rx_pattern_irq_en),
        .rx_pattern_irq_val(rx_pattern_irq_val), .irq_clear(irq_clear), .irq_status(irq_status),
        .fifo_stat(fifo_stat), .scc_addr(scc_addr), .scc_wr(scc_wr), .scc_rd(scc_rd),
        .scc_wdata(scc_wdata), .scc_rdata(scc_rdata), .wait_req_a(wait_req_a),
        .term_ready_req_a(term_ready_req_a), .rx_req_b(rx_req_b),
        .tx_clk_pin_b(tx_clk_pin_b), .line_rxd(line_rxd), .line_rx_clk(line_rx_clk),
        .line_dsr(line_dsr), .rx_data_a(rx_data_a), .rx_data_b(rx_data_b),
        .rx_clk_in_a(rx_clk_in_a), .rx_clk_in_b(rx_clk_in_b), .carrier_in_b(carrier_in_b),
        .clear_to_send_b_n(clear_to_send_b_n), .sync_in_b_n(sync_in_b_n),
        .brg_clk(brg_clk), .line_code_a(line_code_a), .line_code_b(line_code_b));
    scg_ctl_model i_ctl (.clk(clk), .scc_addr(scc_addr), .scc_wr(scc_wr), .scc_rd(scc_rd),
        .scc_wdata(scc_wdata), .scc_rdata(scc_rdata), .wr_log(wr_log), .wr_cnt(wr_cnt));
    //=============================================================
    // shared helpers
    task automatic conclude();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic cyc_wait(input int k);
        repeat (k) @(negedge clk);
    endtask
    // one host access: wait for ready, one-cycle strobe, bounded wait for ack
    task automatic acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (io_ready !== 1'b1 && n < 20) begin
            cyc_wait(1);
            n++;
        end
        io_addr = a;
        io_wdata = d;
        io_wr = wr;
        io_rd = !wr;
        cyc_wait(1);
        io_wr = 0;
        io_rd = 0;
        n = 0;
        while (io_ack !== 1'b1 && n < 10) begin
            cyc_wait(1);
            n++;
        end
        chk("io_ack", 10'h001, {9'h000, io_ack});
    endtask
    //=============================================================
    // scenarios
    task automatic t_reset();
        chk("fifo_stat", 10'h009, {4'h0, fifo_stat});
        chk("held_off", 10'h003, {8'h00, clear_to_send_b_n, sync_in_b_n});
    endtask
    task automatic t_pass();
        n0 = wr_cnt;
        acc(1, ADR_DATA_B, 8'hA5);
        chk("pass_wr", {ADR_DATA_B, 8'hA5}, wr_log[n0[2:0]]);
        acc(0, ADR_DATA_A, 8'h00);
        chk("pass_rd", 10'h050, {2'b00, io_rdata});
    endtask
    task automatic t_ctrl();
        fifo_en = 1;
        acc(1, ADR_CTRL_A, 8'h01);
        acc(1, ADR_CTRL_A, 8'h00);
        acc(1, ADR_CTRL_A, 8'h03);
        acc(0, ADR_CTRL_A, 8'h00);
        chk("irq_pending", 10'h051, {2'b00, io_rdata});
        acc(1, ADR_CTRL_A, 8'h09);
        acc(1, ADR_CTRL_A, 8'hFF);
        chk("irq_ctrl", {ADR_CTRL_A, 8'hDF}, wr_log[(wr_cnt - 1) % 8]);
        acc(1, ADR_CTRL_A, 8'h0A);
        acc(1, ADR_CTRL_A, 8'h60);
        chk("line_code_a", 10'h003, {8'h00, line_code_a});
        acc(1, ADR_CTRL_B, 8'h08);
        acc(1, ADR_CTRL_B, 8'h3C);
        chk("ctrl_buf", {ADR_CTRL_B, 8'h3C}, wr_log[(wr_cnt - 1) % 8]);
    endtask
    // constant 2 reloads every third cycle, so the output flips each 3 cycles
    task automatic t_brg();
        acc(1, ADR_CTRL_A, 8'h0C);
        acc(1, ADR_CTRL_A, 8'h02);
        acc(1, ADR_CTRL_A, 8'h0D);
        acc(1, ADR_CTRL_A, 8'h00);
        acc(1, ADR_CTRL_A, 8'h0E);
        acc(1, ADR_CTRL_A, 8'h01);
        cyc_wait(2);
        n0 = brg_clk[0];
        cyc_wait(3);
        chk("brg_clk", {9'h000, ~n0[0]}, {9'h000, brg_clk[0]});
    endtask
    task automatic t_tx();
        n0 = wr_cnt;
        acc(1, ADR_DATA_A, 8'h11);
        acc(1, ADR_DATA_B, 8'h22);
        tx_fifo_rst = 1;
        cyc_wait(3);
        tx_fifo_rst = 0;
        chk("tx_kept", 10'h000, {9'h000, fifo_stat[0]});
        chk("tx_idle", n0, wr_cnt);
        term_ready_req_a = 1;
        cyc_wait(25);
        term_ready_req_a = 0;
        chk("tx_first", {ADR_DATA_A, 8'h11}, wr_log[n0[2:0]]);
        chk("tx_second", {ADR_DATA_A, 8'h22}, wr_log[(n0 + 1) % 8]);
        chk("tx_count", n0 + 2, wr_cnt);
    endtask
    task automatic t_rx();
        rx_pattern_irq_en = 1;
        rx_pattern_irq_val = 8'h52;
        for (int i = 1; i >= 0; i--) begin
            rx_source_sel = i[0];
            rx_req_b = i[0];
            wait_req_a = !i[0];
            cyc_wait(4);
            rx_req_b = 0;
            wait_req_a = 0;
            cyc_wait(10);
            acc(0, ADR_DATA_B, 8'h00);
            chk("rx_byte", 10'h050 + 10'(2 * i), {2'b00, io_rdata});
            acc(0, ADR_DATA_A, 8'h00);
            chk("rx_empty_rd", 10'h000, {2'b00, io_rdata});
        end
        chk("irq_status", 10'h008, {6'h00, irq_status});
        irq_clear = 4'h8;
        cyc_wait(1);
        irq_clear = 0;
        cyc_wait(1);
        chk("irq_cleared", 10'h000, {6'h00, irq_status});
    endtask
    task automatic t_route();
        line_rxd = 1;
        line_rx_clk = 1;
        line_dsr = 1;
        cyc_wait(4);
        chk("route_off", 10'h01F, {5'h00, rx_data_a, rx_data_b, rx_clk_in_a, rx_clk_in_b,
            carrier_in_b});
        rx_clk_route_en = 1;
        cyc_wait(1);
        chk("route_on", 10'h01B, {5'h00, rx_data_a, rx_data_b, rx_clk_in_a, rx_clk_in_b,
            carrier_in_b});
    endtask
    //=============================================================
    // clock, watchdog and main sequence
    initial forever #50 clk = ~clk;
    // ceiling well beyond the roughly 120 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        cyc_wait(5);
        sys_rst = 0;
        cyc_wait(2);
        t_reset();
        t_pass();
        t_ctrl();
        t_brg();
        t_tx();
        t_rx();
        t_route();
        conclude();
    end
endmodule
`default_nettype wire

/* include/scg_fifo_if.sv */
// byte fifo carrier between the glue and its fifo stores
`timescale 1ns/1ns
`default_nettype none
interface scg_fifo_if;
    logic push;
    logic pop;
    logic clr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic full;
    logic empty;
    logic half;
    modport store (input push, pop, clr, wdata, output rdata, full, empty, half);
    modport user (output push, pop, clr, wdata, input rdata, full, empty, half);
endinterface
`default_nettype wire

/* include/scg_pkg.sv */
// shared constants and types for the serial card fifo glue
//=============================================================
// Operation
// - baud generator 16-bit down counter, divide by two
// - line coding chosen by control bits 6 and 5
// - both receive data joined; receive clocks joined unless rx_clk_route_en set
// - channel B request moves received bytes when selected
// - channel B transmit clock routes to A receive clock
// - connector ready line drives channel B carrier input
// - channel B handshake inputs inactive, outputs left open
// - soft interrupt acknowledge enable forced to zero
// - 1024-byte external fifos for transmit and receive
// - fifos disabled after power-up or insertion
// - one bit enables both fifos together
// - enabled data port write pushes, read pops
// - disabled data ports reach controller channel directly
// - control port buffer accesses always reach controller
// - transmit fifo always feeds channel A transmitter
// - receive source bit picks channel B or A
// - fifo transfers paced by controller requests, hardware only
// - receive source selects which request lines serve
// - fifo reset ignored while enabled, clears pointers
// - sticky fifo interrupt flags, write one clears
package scg_pkg;
    //=============================================================
    // host port offsets
    localparam logic [1:0] ADR_DATA_A = 2'h0;
    localparam logic [1:0] ADR_CTRL_A = 2'h1;
    localparam logic [1:0] ADR_DATA_B = 2'h2;
    localparam logic [1:0] ADR_CTRL_B = 2'h3;
    //=============================================================
    // controller register numbers and bit positions
    localparam logic [3:0] REG_BUF = 4'h8;
    localparam logic [3:0] REG_IRQ = 4'h9;
    localparam logic [3:0] REG_CODE = 4'hA;
    localparam logic [3:0] REG_TCL = 4'hC;
    localparam logic [3:0] REG_TCH = 4'hD;
    localparam logic [3:0] REG_DIAG = 4'hE;
    localparam int SOFT_ACK_BIT = 5;
    localparam int CODE_HI_BIT = 6;
    localparam int CODE_LO_BIT = 5;
    localparam int BRG_EN_BIT = 0;
    localparam logic [2:0] PTR_HIGH_CMD = 3'h1;
    //=============================================================
    // fifo geometry and interrupt status bits
    localparam int FIFO_AW = 10;
    localparam int FIFO_DEPTH = 1024;
    localparam int FIFO_HALF = 512;
    localparam int IRQ_TX_BIT = 1;
    localparam int IRQ_RX_BIT = 2;
    localparam int IRQ_PAT_BIT = 3;
    //=============================================================
    // timing
    localparam int CLK_NS = 100;
    localparam int RX_TMO_NS = 400000;
    localparam int RX_TMO_CYC = RX_TMO_NS / CLK_NS;
    localparam logic [2:0] REQ_HOLD_CYC = 3'h3;
    localparam logic PIN_INACTIVE = 1'b1;
    typedef enum logic [2:0] {ST_IDLE, ST_HOST, ST_XCAP, ST_HOLD} scg_state_t;
endpackage

/* rtl/scg_brg.sv */
// baud generator: reloading down counter plus divide by two
`timescale 1ns/1ns
`default_nettype none
module scg_brg
    import scg_pkg::*;
(
    input wire logic clk,          // card clock
    input wire logic sys_rst,      // sync reset
    input wire logic [15:0] tc,    // time constant
    input wire logic load,         // constant rewritten
    input wire logic en,           // generator enable
    output logic brg_clk           // divided output
);
    typedef struct packed {
        logic [15:0] cnt;
        logic out;
    } scg_bst_t;
    scg_bst_t q;
    scg_bst_t d;

    // terminal count reloads and toggles, giving the halving
    always_comb begin
        d = q;
        if (load || !en) begin
            d.cnt = tc;
        end else if (q.cnt == '0) begin
            d.cnt = tc;
            d.out = ~q.out;
        end else begin
            d.cnt = q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign brg_clk = q.out;
endmodule
`default_nettype wire

/* rtl/scg_fifo.sv */
// 1024 x 8 byte fifo with show-ahead read
`timescale 1ns/1ns
`default_nettype none
module scg_fifo
    import scg_pkg::*;
(
    input wire logic clk,       // card clock
    input wire logic sys_rst,   // sync reset
    scg_fifo_if.store f         // push/pop side
);
    typedef struct packed {
        logic [FIFO_AW:0] wp;
        logic [FIFO_AW:0] rp;
    } scg_fst_t;
    scg_fst_t q;
    scg_fst_t d;
    logic [7:0] mem [FIFO_DEPTH];
    logic [FIFO_AW:0] used;

    //=============================================================
    // flags from the pointer difference
    assign used = q.wp - q.rp;
    assign f.full = used[FIFO_AW];
    assign f.empty = (used == '0);
    assign f.half = (used >= (FIFO_AW+1)'(FIFO_HALF));
    assign f.rdata = mem[q.rp[FIFO_AW-1:0]];

    // clear only resets pointers, data left stale
    always_comb begin
        d = q;
        if (f.clr) begin
            d.wp = '0;
            d.rp = '0;
        end else begin
            if (f.push && !f.full) begin
                d.wp = q.wp + 1'b1;
            end
            if (f.pop && !f.empty) begin
                d.rp = q.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // storage without reset keeps it a plain ram
    always_ff @(posedge clk) begin
        if (f.push && !f.full && !f.clr) begin
            mem[q.wp[FIFO_AW-1:0]] <= f.wdata;
        end
    end

    a_fifo_clear: assert property (@(posedge clk) disable iff (sys_rst)
        f.clr |=> f.empty && !f.half) else $error("fifo not empty after clear");
endmodule
`default_nettype wire

/* rtl/scg_top.sv */
// serial card glue: port decode, fifo steering, pin routing
`timescale 1ns/1ns
`default_nettype none
module scg_top
    import scg_pkg::*;
(
    input wire logic clk,               // card clock 10 MHz
    input wire logic sys_rst,           // sync reset, high
    input wire logic [1:0] io_addr,     // host port offset
    input wire logic io_wr,             // host write pulse
    input wire logic io_rd,             // host read pulse
    input wire logic [7:0] io_wdata,    // host write byte
    output logic [7:0] io_rdata,        // host read byte
    output logic io_ack,                // access done pulse
    output logic io_ready,              // may take a request
    input wire logic fifo_en,           // enable both fifos
    input wire logic rx_source_sel,     // rx fifo from channel B
    input wire logic rx_clk_route_en,   // B tx clock to A rx clock
    input wire logic tx_fifo_rst,       // tx fifo reset command
    input wire logic rx_fifo_rst,       // rx fifo reset command
    input wire logic rx_tmo_en,         // rx timeout enable
    input wire logic rx_pattern_irq_en,         // pattern detect enable
    input wire logic [7:0] rx_pattern_irq_val,  // pattern byte
    input wire logic [3:0] irq_clear,   // write-one clear
    output logic [3:0] irq_status,      // sticky fifo flags
    output logic [5:0] fifo_stat,       // empty/full/half tx,rx
    output logic [1:0] scc_addr,        // controller port
    output logic scc_wr,                // controller write strobe
    output logic scc_rd,                // controller read strobe
    output logic [7:0] scc_wdata,       // controller write byte
    input wire logic [7:0] scc_rdata,   // controller read byte
    input wire logic wait_req_a,        // channel A wait/request
    input wire logic term_ready_req_a,  // channel A ready/request
    input wire logic rx_req_b,          // channel B wait/request
    input wire logic tx_clk_pin_b,      // channel B clock out
    input wire logic line_rxd,          // connector rx data
    input wire logic line_rx_clk,       // connector rx clock
    input wire logic line_dsr,          // connector data set ready
    output logic rx_data_a,             // to channel A rx data
    output logic rx_data_b,             // to channel B rx data
    output logic rx_clk_in_a,           // to channel A rx clock
    output logic rx_clk_in_b,           // to channel B rx clock
    output logic carrier_in_b,          // to channel B carrier
    output logic clear_to_send_b_n,     // channel B cts, held off
    output logic sync_in_b_n,           // channel B sync, held off
    output logic [1:0] brg_clk,         // baud clocks A, B
    output logic [1:0] line_code_a,     // channel A coding
    output logic [1:0] line_code_b      // channel B coding
);
    typedef struct packed {
        scg_state_t st;
        logic [2:0] rq1;
        logic [2:0] rq2;
        logic [1:0] dsr;
        logic [1:0] adr;
        logic wr;
        logic rd;
        logic [7:0] wd;
        logic [7:0] hrd;
        logic ack;
        logic rdy;
        logic [2:0] hold;
        logic [1:0] phase;
        logic [1:0][3:0] ptr;
        logic [1:0][7:0] tcl;
        logic [1:0][7:0] tch;
        logic [1:0][7:0] code;
        logic [1:0][7:0] diag;
        logic [1:0] tc_ld;
        logic [3:0] irq;
        logic txh;
        logic rxh;
        logic [11:0] tmo;
        logic [5:0] stat;
    } scg_st_t;
    scg_st_t q;
    scg_st_t d;
    scg_fifo_if txf ();
    scg_fifo_if rxf ();
    logic tx_req;
    logic rx_req;
    logic ch;
    logic [3:0] irq_set;

    //=============================================================
    // fifo stores
    scg_fifo u_txf (.clk(clk), .sys_rst(sys_rst), .f(txf.store));
    scg_fifo u_rxf (.clk(clk), .sys_rst(sys_rst), .f(rxf.store));

    //=============================================================
    // one baud generator per channel from shadowed constants
    for (genvar g = 0; g < 2; g++) begin : g_brg
        scg_brg u_brg (
            .clk(clk),
            .sys_rst(sys_rst),
            .tc({q.tch[g], q.tcl[g]}),
            .load(q.tc_ld[g]),
            .en(q.diag[g][BRG_EN_BIT]),
            .brg_clk(brg_clk[g])
        );
    end

    //=============================================================
    // request lines chosen by receive source
    always_comb begin
        tx_req = rx_source_sel ? q.rq2[0] : q.rq2[1];
        rx_req = rx_source_sel ? q.rq2[2] : q.rq2[0];
    end

    //=============================================================
    // main sequencer: host accesses first, then fifo transfers
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.tc_ld = '0;
        irq_set = '0;
        ch = io_addr[1];
        txf.push = 1'b0;
        txf.pop = 1'b0;
        txf.wdata = io_wdata;
        rxf.push = 1'b0;
        rxf.pop = 1'b0;
        rxf.wdata = scc_rdata;
        // reset commands only honoured while fifos are off
        txf.clr = tx_fifo_rst && !fifo_en;
        rxf.clr = rx_fifo_rst && !fifo_en;
        // asynchronous pins pass two flops first
        d.rq1 = {rx_req_b, term_ready_req_a, wait_req_a};
        d.rq2 = q.rq1;
        d.dsr = {q.dsr[0], line_dsr};
        case (q.st)
            ST_IDLE: begin
                d.rdy = 1'b1;
                if (q.rdy && (io_wr || io_rd)) begin
                    if (fifo_en && !io_addr[0]) begin
                        // either data port maps onto the fifo pair
                        txf.push = io_wr && !txf.full;
                        rxf.pop = io_rd && !rxf.empty;
                        // a fifo write leaves the last read byte standing
                        if (io_rd) begin
                            d.hrd = rxf.empty ? 8'h00 : rxf.rdata;
                        end
                        d.ack = 1'b1;
                    end else begin
                        // data port off-fifo or control port: straight through
                        d.adr = io_addr;
                        d.wr = io_wr;
                        d.rd = io_rd;
                        d.wd = io_wdata;
                        d.rdy = 1'b0;
                        d.st = ST_HOST;
                        if (io_addr[0] && io_wr && !q.phase[ch]) begin
                            // pointer write; next access on this port only
                            d.ptr[ch] = {io_wdata[5:3] == PTR_HIGH_CMD, io_wdata[2:0]};
                            d.phase[ch] = (d.ptr[ch] != '0);
                        end else if (io_addr[0] && q.phase[ch]) begin
                            d.phase[ch] = 1'b0;
                            if (io_wr) begin
                                case (q.ptr[ch])
                                    REG_IRQ: d.wd[SOFT_ACK_BIT] = 1'b0;
                                    REG_CODE: d.code[ch] = io_wdata;
                                    REG_TCL: begin
                                        d.tcl[ch] = io_wdata;
                                        d.tc_ld[ch] = 1'b1;
                                    end
                                    REG_TCH: begin
                                        d.tch[ch] = io_wdata;
                                        d.tc_ld[ch] = 1'b1;
                                    end
                                    REG_DIAG: d.diag[ch] = io_wdata;
                                    default: d.diag[ch] = q.diag[ch];
                                endcase
                            end
                        end
                    end
                end else if (fifo_en && tx_req && !txf.empty) begin
                    // tx fifo always drains into channel A
                    d.adr = ADR_DATA_A;
                    d.wr = 1'b1;
                    d.wd = txf.rdata;
                    txf.pop = 1'b1;
                    d.rdy = 1'b0;
                    d.hold = REQ_HOLD_CYC;
                    d.st = ST_HOLD;
                end else if (fifo_en && rx_req && !rxf.full) begin
                    d.adr = rx_source_sel ? ADR_DATA_B : ADR_DATA_A;
                    d.rd = 1'b1;
                    d.rdy = 1'b0;
                    d.st = ST_XCAP;
                end
            end
            ST_HOST: begin
                if (q.rd) begin
                    d.hrd = scc_rdata;
                end
                d.ack = 1'b1;
                d.rdy = 1'b1;
                d.st = ST_IDLE;
            end
            ST_XCAP: begin
                rxf.push = 1'b1;
                irq_set[IRQ_PAT_BIT] = rx_pattern_irq_en && (scc_rdata == rx_pattern_irq_val);
                d.hold = REQ_HOLD_CYC;
                d.st = ST_HOLD;
            end
            ST_HOLD: begin
                // synchronised request needs time to fall after a strobe
                if (q.hold == '0) begin
                    d.rdy = 1'b1;
                    d.st = ST_IDLE;
                end else begin
                    d.hold = q.hold - 3'h1;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        //=========================================================
        // interrupt sources; set beats a same-cycle clear
        d.txh = txf.half;
        d.rxh = rxf.half;
        irq_set[IRQ_TX_BIT] = q.txh && !txf.half;
        if (!rxf.empty && rx_tmo_en && !rxf.push && !rxf.pop) begin
            if (q.tmo != 12'(RX_TMO_CYC)) begin
                d.tmo = q.tmo + 12'h001;
            end
        end else begin
            d.tmo = '0;
        end
        irq_set[IRQ_RX_BIT] = (!q.rxh && rxf.half) ||
            (q.tmo == 12'(RX_TMO_CYC - 1) && d.tmo == 12'(RX_TMO_CYC));
        d.irq = (q.irq & ~irq_clear) | irq_set;
        d.stat = {rxf.half, rxf.full, rxf.empty, txf.half, txf.full, txf.empty};
    end

    // fifo enable is external and is not cleared by this reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    //=============================================================
    // registered outputs
    assign io_rdata = q.hrd;
    assign io_ack = q.ack;
    assign io_ready = q.rdy;
    assign irq_status = q.irq;
    assign fifo_stat = q.stat;
    assign scc_addr = q.adr;
    assign scc_wr = q.wr;
    assign scc_rd = q.rd;
    assign scc_wdata = q.wd;
    assign carrier_in_b = q.dsr[1];
    assign line_code_a = {q.code[0][CODE_HI_BIT], q.code[0][CODE_LO_BIT]};
    assign line_code_b = {q.code[1][CODE_HI_BIT], q.code[1][CODE_LO_BIT]};
    // channel B tx data, ready and rts outputs are simply not taken
    assign clear_to_send_b_n = PIN_INACTIVE;
    assign sync_in_b_n = PIN_INACTIVE;

    // serial clock and data stay combinational: resampling adds jitter
    assign rx_data_a = line_rxd;
    assign rx_data_b = line_rxd;
    assign rx_clk_in_b = line_rx_clk;
    assign rx_clk_in_a = rx_clk_route_en ? tx_clk_pin_b : line_rx_clk;

    //=============================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_settle;
        (!scc_rd && !scc_wr) [*4] ##1 q.st == ST_IDLE;
    endsequence

    a_soft_ack_zero: assert property (q.rdy && io_wr && io_addr[0] && q.phase[io_addr[1]] &&
        q.ptr[io_addr[1]] == REG_IRQ |=> scc_wr && !scc_wdata[SOFT_ACK_BIT])
        else $error("soft ack enable reached controller");
    a_fifo_write: assert property (q.rdy && io_wr && fifo_en && !io_addr[0] |=>
        !scc_wr ##1 (!scc_wr || q.st == ST_HOLD)) else $error("fifo write leaked to controller");
    a_direct_data: assert property (q.rdy && io_wr && !fifo_en && !io_addr[0] |=>
        scc_wr && scc_addr == $past(io_addr) && scc_wdata == $past(io_wdata) ##1 io_ack)
        else $error("direct data write wrong");
    a_ctrl_direct: assert property (q.rdy && io_rd && io_addr[0] |=>
        scc_rd && scc_addr == $past(io_addr) ##1 io_ack && io_rdata == $past(scc_rdata))
        else $error("control read not passed through");
    a_tx_chan_a: assert property (scc_wr && q.st == ST_HOLD |-> scc_addr == ADR_DATA_A)
        else $error("tx transfer not to channel A");
    a_rx_source: assert property (q.st == ST_XCAP |->
        scc_addr == ($past(rx_source_sel) ? ADR_DATA_B : ADR_DATA_A) && $past(fifo_en))
        else $error("rx transfer from wrong channel");
    a_rx_settle: assert property (q.st == ST_XCAP |=> s_settle)
        else $error("transfer spacing wrong");
    a_irq_sticky: assert property (q.irq[IRQ_RX_BIT] && !irq_clear[IRQ_RX_BIT] |=>
        irq_status[IRQ_RX_BIT]) else $error("rx flag lost without clear");
    a_rst_ignored: assert property (fifo_en && !txf.empty && !txf.pop |=> !txf.empty)
        else $error("tx fifo emptied while enabled");
endmodule
`default_nettype wire
